// ==== rtl/charger_status_fault_regs.vh ====
// Register offsets, field positions and reset values of the charger status and fault bank.
`ifndef CHARGER_STATUS_FAULT_REGS_VH
`define CHARGER_STATUS_FAULT_REGS_VH
// Printed offsets are register indexes; byte address is four times the index.
`define IDX_STATE_REPORT    4'h8
`define IDX_FAULT_REPORT    4'h9
`define IDX_REG_STATE_MASK  4'ha
`define IDX_IDENT_RESET     4'hb
`define IDX_TEMP_ZONE_CTRL  4'hc
// Mask bit positions in the regulation register.
`define BIT_VLOOP_MASK      1
`define BIT_ILOOP_MASK      0
// Register reset bit in the identity register.
`define BIT_SOFT_RESET      7
// Temperature zone control field positions.
`define BIT_COOL_VCAP       7
`define BIT_COOL_EN         6
`define MSB_WARM_ISCALE     5
`define LSB_WARM_ISCALE     4
`define MSB_COOL_THR        3
`define LSB_COOL_THR        2
`define MSB_WARM_THR        1
`define LSB_WARM_THR        0
// Reset values.
`define RST_TEMP_ZONE_CTRL  8'h75
`define RST_MASKS           2'h0
`define RST_SOFT_RESET      1'h0
// Warm zone current scale codes in percent.
`define PCT_ZERO            7'h00
`define PCT_TWENTY          7'h14
`define PCT_FIFTY           7'h32
`define PCT_FULL            7'h64
// Cool zone voltage cap in millivolts.
`define COOL_VCAP_MV        13'h1004
`endif

// ==== rtl/charger_status_fault_regs.v ====
// Status, fault, identity and temperature zone registers of the charger, on classic Wishbone.
`include "charger_status_fault_regs.vh"

module charger_status_fault_regs #(
   parameter [3:0] PART_CODE     = 4'h5,  // Arbitrary value.
   parameter [0:0] MAKER_FLAG    = 1'h0,  // Arbitrary value.
   parameter [1:0] SILICON_REV   = 2'h0,  // Arbitrary value.
   parameter       VREG_MV_WIDTH = 13
) (
   // Clock and reset
   input  wire                     clk_sys_in,
   input  wire                     rst_b_in,
   // Wishbone slave
   input  wire                     wb_cyc_in,
   input  wire                     wb_stb_in,
   input  wire                     wb_we_in,
   input  wire [5:0]               wb_adr_in,
   input  wire [3:0]               wb_sel_in,
   input  wire [31:0]              wb_dat_in,
   output reg  [31:0]              wb_dat_out,
   output reg                      wb_ack_out,
   // Status inputs from the analog side, and the programmed regulation voltage
   input  wire [2:0]               input_source_type_in,
   input  wire [1:0]               charge_phase_in,
   input  wire                     input_power_good_in,
   input  wire                     die_thermal_loop_active_in,
   input  wire                     min_system_rail_loop_active_in,
   input  wire                     watchdog_expired_in,
   input  wire                     boost_fault_in,
   input  wire [1:0]               charge_fault_code_in,
   input  wire                     battery_overvoltage_flag_in,
   input  wire [2:0]               battery_temp_zone_in,
   input  wire                     input_attached_good_in,
   input  wire                     input_voltage_loop_active_in,
   input  wire                     input_current_loop_active_in,
   input  wire                     constant_voltage_phase_in,
   input  wire                     topoff_timer_running_in,
   input  wire                     adaptor_overvoltage_flag_in,
   input  wire [VREG_MV_WIDTH-1:0] programmed_vreg_mv_in,
   // Charge control outputs and interrupt pulse
   output reg  [VREG_MV_WIDTH-1:0] cool_zone_vreg_mv_out,
   output reg                      cool_zone_charge_allowed_out,
   output reg  [6:0]               warm_zone_current_pct_out,
   output wire                     warm_zone_timer_slow_out,
   output reg  [1:0]               cool_zone_threshold_out,
   output reg  [1:0]               warm_zone_threshold_out,
   output reg                      safety_timer_reset_out,
   output reg                      irq_pulse_out
);

   reg  [1:0]    masks_q;
   reg           soft_reset_q;
   reg  [7:0]    zone_ctrl_q;
   reg           vloop_prev_q;
   reg           iloop_prev_q;
   reg           wd_prev_q;

   wire [2:0] src_type;
   wire [1:0] phase;
   wire       pwr_good;
   wire       therm_loop;
   wire       sys_loop;
   wire       wd_fault;
   wire       boost_flt;
   wire [1:0] chg_fault;
   wire       bat_ovp;
   wire [2:0] temp_zone;
   wire       attached;
   wire       vloop;
   wire       iloop;
   wire       cv_phase;
   wire       topoff;
   wire       adaptor_ov;
   // Every status level comes from the analog side, so each passes two flip-flops.
   status_level_sync #(
      .WIDTH(3)
   ) u_sync_src_type (
      .clk_sys_in (clk_sys_in),
      .rst_b_in   (rst_b_in),
      .level_in   (input_source_type_in),
      .level_out  (src_type)
   );

   status_level_sync #(
      .WIDTH(2)
   ) u_sync_phase (
      .clk_sys_in (clk_sys_in),
      .rst_b_in   (rst_b_in),
      .level_in   (charge_phase_in),
      .level_out  (phase)
   );

   status_level_sync u_sync_pwr_good (
      .clk_sys_in (clk_sys_in),
      .rst_b_in   (rst_b_in),
      .level_in   (input_power_good_in),
      .level_out  (pwr_good)
   );

   status_level_sync u_sync_therm_loop (
      .clk_sys_in (clk_sys_in),
      .rst_b_in   (rst_b_in),
      .level_in   (die_thermal_loop_active_in),
      .level_out  (therm_loop)
   );

   status_level_sync u_sync_sys_loop (
      .clk_sys_in (clk_sys_in),
      .rst_b_in   (rst_b_in),
      .level_in   (min_system_rail_loop_active_in),
      .level_out  (sys_loop)
   );

   status_level_sync u_sync_wd_fault (
      .clk_sys_in (clk_sys_in),
      .rst_b_in   (rst_b_in),
      .level_in   (watchdog_expired_in),
      .level_out  (wd_fault)
   );

   status_level_sync u_sync_boost_flt (
      .clk_sys_in (clk_sys_in),
      .rst_b_in   (rst_b_in),
      .level_in   (boost_fault_in),
      .level_out  (boost_flt)
   );

   status_level_sync #(
      .WIDTH(2)
   ) u_sync_chg_fault (
      .clk_sys_in (clk_sys_in),
      .rst_b_in   (rst_b_in),
      .level_in   (charge_fault_code_in),
      .level_out  (chg_fault)
   );

   status_level_sync u_sync_bat_ovp (
      .clk_sys_in (clk_sys_in),
      .rst_b_in   (rst_b_in),
      .level_in   (battery_overvoltage_flag_in),
      .level_out  (bat_ovp)
   );

   status_level_sync #(
      .WIDTH(3)
   ) u_sync_temp_zone (
      .clk_sys_in (clk_sys_in),
      .rst_b_in   (rst_b_in),
      .level_in   (battery_temp_zone_in),
      .level_out  (temp_zone)
   );

   status_level_sync u_sync_attached (
      .clk_sys_in (clk_sys_in),
      .rst_b_in   (rst_b_in),
      .level_in   (input_attached_good_in),
      .level_out  (attached)
   );

   status_level_sync u_sync_vloop (
      .clk_sys_in (clk_sys_in),
      .rst_b_in   (rst_b_in),
      .level_in   (input_voltage_loop_active_in),
      .level_out  (vloop)
   );

   status_level_sync u_sync_iloop (
      .clk_sys_in (clk_sys_in),
      .rst_b_in   (rst_b_in),
      .level_in   (input_current_loop_active_in),
      .level_out  (iloop)
   );

   status_level_sync u_sync_cv_phase (
      .clk_sys_in (clk_sys_in),
      .rst_b_in   (rst_b_in),
      .level_in   (constant_voltage_phase_in),
      .level_out  (cv_phase)
   );

   status_level_sync u_sync_topoff (
      .clk_sys_in (clk_sys_in),
      .rst_b_in   (rst_b_in),
      .level_in   (topoff_timer_running_in),
      .level_out  (topoff)
   );

   status_level_sync u_sync_adaptor_ov (
      .clk_sys_in (clk_sys_in),
      .rst_b_in   (rst_b_in),
      .level_in   (adaptor_overvoltage_flag_in),
      .level_out  (adaptor_ov)
   );

   // Bus decode; the slave answers in the cycle after the strobe and drops ack for one cycle.
   wire       req       = wb_cyc_in & wb_stb_in & ~wb_ack_out;
   wire [3:0] idx       = wb_adr_in[5:2];
   // A write lands at the edge where the master samples ack, never while it still waits.
   wire       wr_lane0  = wb_cyc_in & wb_stb_in & wb_ack_out & wb_we_in & wb_sel_in[0] &
                          (wb_adr_in[1:0] == 2'h0);
   wire       wr_mask   = wr_lane0 & (idx == `IDX_REG_STATE_MASK);
   wire       wr_ident  = wr_lane0 & (idx == `IDX_IDENT_RESET);
   wire       wr_zone   = wr_lane0 & (idx == `IDX_TEMP_ZONE_CTRL);
   // Watchdog expiry restores the zone settings once on its rising edge.
   wire       wd_rise   = wd_fault & ~wd_prev_q;

   function [7:0] read_mux;
      input [3:0] i;
      begin
         case (i)
            `IDX_STATE_REPORT:   read_mux = {src_type, phase, pwr_good, therm_loop,
                                             sys_loop};
            `IDX_FAULT_REPORT:   read_mux = {wd_fault, boost_flt,
                                             chg_fault, bat_ovp,
                                             temp_zone};
            `IDX_REG_STATE_MASK: read_mux = {attached, vloop, iloop,
                                             cv_phase, topoff,
                                             adaptor_ov, masks_q};
            `IDX_IDENT_RESET:    read_mux = {soft_reset_q, PART_CODE, MAKER_FLAG,
                                             SILICON_REV};
            `IDX_TEMP_ZONE_CTRL: read_mux = zone_ctrl_q;
            default:             read_mux = 8'h00;
         endcase
      end
   endfunction

   // Reads only sample; no register changes on a read.
   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         wb_ack_out <= 1'b0;
         wb_dat_out <= 32'h0000_0000;
      end else begin
         wb_ack_out <= req;
         if (req && !wb_we_in) begin
            wb_dat_out <= {24'h00_0000, read_mux(idx)};
         end
      end
   end

   // The soft reset bit is held for one cycle, during which defaults load, then it clears itself.
   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         masks_q                <= `RST_MASKS;
         soft_reset_q           <= `RST_SOFT_RESET;
         zone_ctrl_q            <= `RST_TEMP_ZONE_CTRL;
         safety_timer_reset_out <= 1'b0;
         wd_prev_q              <= 1'b0;
      end else begin
         wd_prev_q              <= wd_fault;
         safety_timer_reset_out <= soft_reset_q;
         if (soft_reset_q) begin
            masks_q      <= `RST_MASKS;
            zone_ctrl_q  <= `RST_TEMP_ZONE_CTRL;
            soft_reset_q <= `RST_SOFT_RESET;
         end else begin
            if (wr_ident) begin
               soft_reset_q <= wb_dat_in[`BIT_SOFT_RESET];
            end
            if (wr_mask) begin
               masks_q <= wb_dat_in[`BIT_VLOOP_MASK:`BIT_ILOOP_MASK];
            end
            if (wd_rise) begin
               zone_ctrl_q <= `RST_TEMP_ZONE_CTRL;
            end else if (wr_zone) begin
               zone_ctrl_q <= wb_dat_in[7:0];
            end
         end
      end
   end

   // Onset of the input voltage or input current loop gives one pulse unless masked.
   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         vloop_prev_q  <= 1'b0;
         iloop_prev_q  <= 1'b0;
         irq_pulse_out <= 1'b0;
      end else begin
         vloop_prev_q  <= vloop;
         iloop_prev_q  <= iloop;
         irq_pulse_out <= (vloop & ~vloop_prev_q & ~masks_q[`BIT_VLOOP_MASK]) |
                          (iloop & ~iloop_prev_q & ~masks_q[`BIT_ILOOP_MASK]);
      end
   end

   function [6:0] warm_pct;
      input [1:0] code;
      begin
         case (code)
            2'h0:    warm_pct = `PCT_ZERO;
            2'h1:    warm_pct = `PCT_TWENTY;
            2'h2:    warm_pct = `PCT_FIFTY;
            default: warm_pct = `PCT_FULL;
         endcase
      end
   endfunction

   // Warm zone never slows the safety timer.
   assign warm_zone_timer_slow_out = 1'b0;

   wire [VREG_MV_WIDTH-1:0] cap_mv = `COOL_VCAP_MV;

   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         cool_zone_vreg_mv_out        <= {VREG_MV_WIDTH{1'b0}};
         cool_zone_charge_allowed_out <= 1'b0;
         warm_zone_current_pct_out    <= `PCT_ZERO;
         cool_zone_threshold_out      <= 2'h0;
         warm_zone_threshold_out      <= 2'h0;
      end else begin
         if (zone_ctrl_q[`BIT_COOL_VCAP] && (programmed_vreg_mv_in > cap_mv)) begin
            cool_zone_vreg_mv_out <= cap_mv;
         end else begin
            cool_zone_vreg_mv_out <= programmed_vreg_mv_in;
         end
         cool_zone_charge_allowed_out <= zone_ctrl_q[`BIT_COOL_EN];
         warm_zone_current_pct_out    <=
            warm_pct(zone_ctrl_q[`MSB_WARM_ISCALE:`LSB_WARM_ISCALE]);
         cool_zone_threshold_out <= zone_ctrl_q[`MSB_COOL_THR:`LSB_COOL_THR];
         warm_zone_threshold_out <= zone_ctrl_q[`MSB_WARM_THR:`LSB_WARM_THR];
      end
   end

endmodule

// Two flip-flop synchroniser; a multi-bit code can look mixed for one cycle while it changes.
module status_level_sync #(
   parameter WIDTH = 1
) (
   // Clock and reset
   input  wire             clk_sys_in,
   input  wire             rst_b_in,
   // Level from outside the clock domain and its synchronised copy
   input  wire [WIDTH-1:0] level_in,
   output wire [WIDTH-1:0] level_out
);

   reg [WIDTH-1:0] stage1_q;
   reg [WIDTH-1:0] stage2_q;

   always @(posedge clk_sys_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         stage1_q <= {WIDTH{1'b0}};
         stage2_q <= {WIDTH{1'b0}};
      end else begin
         stage1_q <= level_in;
         stage2_q <= stage1_q;
      end
   end

   assign level_out = stage2_q;

endmodule

// ==== bench/charger_status_fault_regs_checker.sv ====
// Concurrent checks on the ports of the charger status and fault register bank.
module charger_status_fault_regs_checker #(
   parameter VREG_MV_WIDTH = 13
) (
   // Clock, reset and bus
   input logic                     clk_sys_in,
   input logic                     rst_b_in,
   input logic                     wb_cyc_in,
   input logic                     wb_stb_in,
   input logic                     wb_we_in,
   input logic [31:0]              wb_dat_out,
   input logic                     wb_ack_out,
   // Analog side and charge control
   input logic                     input_voltage_loop_active_in,
   input logic                     input_current_loop_active_in,
   input logic                     watchdog_expired_in,
   input logic [VREG_MV_WIDTH-1:0] programmed_vreg_mv_in,
   input logic [VREG_MV_WIDTH-1:0] cool_zone_vreg_mv_out,
   input logic                     cool_zone_charge_allowed_out,
   input logic [6:0]               warm_zone_current_pct_out,
   input logic                     warm_zone_timer_slow_out,
   input logic [1:0]               cool_zone_threshold_out,
   input logic [1:0]               warm_zone_threshold_out,
   input logic                     safety_timer_reset_out,
   input logic                     irq_pulse_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!rst_b_in);
   sequence s_defaults;
      cool_zone_charge_allowed_out && warm_zone_current_pct_out == 7'h64 &&
      cool_zone_threshold_out == 2'h1 && warm_zone_threshold_out == 2'h1;
   endsequence
   property p_ack;
      wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out ##1 !wb_ack_out;
   endproperty
   a_ack: assert property (p_ack) else $error("ack not a single pulse after request");
   property p_noack; !(wb_cyc_in && wb_stb_in) |=> !wb_ack_out; endproperty
   a_noack: assert property (p_noack) else $error("ack without request");
   property p_rdata; wb_ack_out && !wb_we_in |-> wb_dat_out[31:8] == 24'h0; endproperty
   a_rdata: assert property (p_rdata) else $error("read data upper bits set");
   property p_vcap;
      $past(rst_b_in) |-> cool_zone_vreg_mv_out == $past(programmed_vreg_mv_in) ||
         cool_zone_vreg_mv_out == 13'h1004 && $past(programmed_vreg_mv_in) > 13'h1004;
   endproperty
   a_vcap: assert property (p_vcap) else $error("cool zone voltage wrong");
   property p_slow; warm_zone_timer_slow_out == 1'b0; endproperty
   a_slow: assert property (p_slow) else $error("warm zone timer slowed");
   property p_irq;
      irq_pulse_out |->
         ($past(input_voltage_loop_active_in, 2) || $past(input_current_loop_active_in, 2))
         ##1 !irq_pulse_out;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt pulse without loop onset");
   property p_safety; safety_timer_reset_out |-> ##[0:2] s_defaults; endproperty
   a_safety: assert property (p_safety) else $error("soft reset left zone settings");
   property p_wd; $rose(watchdog_expired_in) |-> ##[2:8] s_defaults; endproperty
   a_wd: assert property (p_wd) else $error("watchdog left zone settings");
endmodule
bind charger_status_fault_regs charger_status_fault_regs_checker #(
   .VREG_MV_WIDTH(VREG_MV_WIDTH)) u_chk (.*);

// ==== bench/charger_status_fault_regs_tb.sv ====
// Self-checking bench for the charger status, fault and zone control registers.
module charger_status_fault_regs_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys_in = 1'b0;
   logic        rst_b_in = 1'b0;
   logic        wb_cyc_in = 1'b0;
   logic        wb_stb_in = 1'b0;
   logic        wb_we_in = 1'b0;
   logic [5:0]  wb_adr_in = 6'h00;
   logic [3:0]  wb_sel_in = 4'hf;
   logic [31:0] wb_dat_in = 32'h0;
   logic [31:0] wb_dat_out, rd;
   logic        wb_ack_out, irq_pulse_out, safety_timer_reset_out, warm_zone_timer_slow_out;
   logic        cool_zone_charge_allowed_out;
   logic [6:0]  warm_zone_current_pct_out;
   logic [1:0]  cool_zone_threshold_out, warm_zone_threshold_out;
   logic [12:0] programmed_vreg_mv_in = 13'h1194;
   logic [12:0] cool_zone_vreg_mv_out;
   int          err_total = 0, tests_run = 0, irqs = 0, strs = 0, n;
   // Status pins in read layout, so each row is both the stimulus and the expected data of the three registers.
   logic [23:0] sv = 24'h0;
   logic [23:0] rows [7] = '{24'h000000, 24'ha8522d, 24'h54ab52, 24'hfc757f, 24'h00cea0,
                             24'h2410ca, 24'h0000f5};
   logic [6:0]  pct [4] = '{7'h00, 7'h14, 7'h32, 7'h64};
   wire [2:0]   input_source_type_in = sv[7:5];
   wire [1:0]   charge_phase_in = sv[4:3];
   wire         input_power_good_in = sv[2];
   wire         die_thermal_loop_active_in = sv[1];
   wire         min_system_rail_loop_active_in = sv[0];
   wire         watchdog_expired_in = sv[15];
   wire         boost_fault_in = sv[14];
   wire [1:0]   charge_fault_code_in = sv[13:12];
   wire         battery_overvoltage_flag_in = sv[11];
   wire [2:0]   battery_temp_zone_in = sv[10:8];
   wire         input_attached_good_in = sv[23];
   wire         input_voltage_loop_active_in = sv[22];
   wire         input_current_loop_active_in = sv[21];
   wire         constant_voltage_phase_in = sv[20];
   wire         topoff_timer_running_in = sv[19];
   wire         adaptor_overvoltage_flag_in = sv[18];
   charger_status_fault_regs DUT (.*);
   always #12.5 clk_sys_in = ~clk_sys_in;
   always @(posedge clk_sys_in) begin
      irqs <= irqs + int'(irq_pulse_out === 1'b1);
      strs <= strs + int'(safety_timer_reset_out === 1'b1);
   end
   task automatic complete_run;
      $display("comparisons %0d mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      tests_run++;
      if (s !== e) begin
         err_total++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
      end
   endtask
   // Classic cycle held until ack; the bound stands in for a hung slave.
   task automatic bus(input logic w, input logic [5:0] a, input logic [7:0] d);
      int k;
      wb_cyc_in <= 1'b1;
      wb_stb_in <= 1'b1;
      wb_we_in <= w;
      wb_adr_in <= a;
      wb_dat_in <= {24'h000000, d};
      k = 0;
      do begin
         @(posedge clk_sys_in);
         k++;
      end while (wb_ack_out !== 1'b1 && k < 16);
      if (wb_ack_out !== 1'b1) begin
         err_total++;
         complete_run();
      end
      rd = wb_dat_out;
      wb_cyc_in <= 1'b0;
      wb_stb_in <= 1'b0;
      @(posedge clk_sys_in);
   endtask
   task automatic rdc(input logic [5:0] a, input logic [31:0] e);
      bus(1'b0, a, 8'h00);
      chk(rd, e);
   endtask
   initial begin
      repeat (8) @(posedge clk_sys_in);
      rst_b_in <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
      chk({cool_zone_charge_allowed_out, warm_zone_current_pct_out}, 8'he4);
      chk({cool_zone_threshold_out, warm_zone_threshold_out}, 4'h5);
      chk(cool_zone_vreg_mv_out, 13'h1194);
      rdc(6'h30, 8'h75);
      bus(1'b1, 6'h2c, 8'h7f);
      rdc(6'h2c, 8'h28);
      bus(1'b1, 6'h3c, 8'hff);
      rdc(6'h3c, 8'h00);
      for (int i = 0; i < 7; i++) begin
         sv <= rows[i];
         repeat (4) @(posedge clk_sys_in);
         rdc(6'h20, rows[i][7:0]);
         rdc(6'h24, rows[i][15:8]);
         rdc(6'h24, rows[i][15:8]);
         rdc(6'h28, rows[i][23:16] & 8'hfc);
      end
      for (int j = 0; j < 4; j++) begin
         bus(1'b1, 6'h30, 8'h8a | 8'(j << 4));
         repeat (2) @(posedge clk_sys_in);
         chk(warm_zone_current_pct_out, pct[j]);
      end
      rdc(6'h30, 8'hba);
      chk({cool_zone_charge_allowed_out, cool_zone_threshold_out, warm_zone_threshold_out},
          5'h0a);
      chk(cool_zone_vreg_mv_out, 13'h1004);
      programmed_vreg_mv_in <= 13'h0fa0;
      repeat (2) @(posedge clk_sys_in);
      chk(cool_zone_vreg_mv_out, 13'h0fa0);
      bus(1'b1, 6'h28, 8'hff);
      rdc(6'h28, 8'h03);
      n = irqs;
      sv <= 24'h600000;
      repeat (8) @(posedge clk_sys_in);
      chk(irqs - n, 0);
      bus(1'b1, 6'h28, 8'h01);
      sv <= 24'h0;
      repeat (6) @(posedge clk_sys_in);
      n = irqs;
      sv <= 24'h200000;
      repeat (8) @(posedge clk_sys_in);
      sv <= 24'h600000;
      repeat (8) @(posedge clk_sys_in);
      chk(irqs - n, 1);
      n = strs;
      bus(1'b1, 6'h2c, 8'h80);
      repeat (4) @(posedge clk_sys_in);
      chk(strs - n, 1);
      rdc(6'h2c, 8'h28);
      rdc(6'h28, 8'h60);
      rdc(6'h30, 8'h75);
      bus(1'b1, 6'h30, 8'h00);
      rdc(6'h30, 8'h00);
      sv <= 24'h008000;
      repeat (6) @(posedge clk_sys_in);
      rdc(6'h30, 8'h75);
      bus(1'b1, 6'h31, 8'h00);
      rdc(6'h30, 8'h75);
      bus(1'b1, 6'h28, 8'h03);
      rst_b_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      chk({cool_zone_charge_allowed_out, warm_zone_current_pct_out}, 8'h00);
      rst_b_in <= 1'b1;
      repeat (2) @(posedge clk_sys_in);
      chk({cool_zone_charge_allowed_out, warm_zone_current_pct_out}, 8'he4);
      rdc(6'h28, 8'h00);
      complete_run();
   end
endmodule
